// >>> inc/mc_qual_pkg.sv
// Shared constants and carriers for the memory controller event qualifier bank.
// Assumes one clock and a privileged register port driven from the same domain.
package mc_qual_pkg;
   // ****************************************
   // Register indices on the privileged port
   // ****************************************
   localparam logic [2:0] IDX_DSP = 3'h0;
   localparam logic [2:0] IDX_ISS = 3'h1;
   localparam logic [2:0] IDX_MAP = 3'h2;
   localparam logic [2:0] IDX_THR = 3'h3;
   localparam logic [2:0] IDX_PGT = 3'h4;
   localparam logic [2:0] IDX_PLD = 3'h5;
   localparam logic [2:0] IDX_FVC = 3'h6;
   // ****************************************
   // Writable bit masks and reset values
   // ****************************************
   localparam logic [63:0] MASK_DSP = 64'h0000_0000_0000_07FF;
   localparam logic [31:0] MASK_ISS = 32'h0000_03FF;
   localparam logic [31:0] MASK_MAP = 32'h0000_0FFF;
   localparam logic [31:0] MASK_THR = 32'h0000_07FF;
   localparam logic [31:0] MASK_PGT = 32'h0000_0FFF;
   localparam logic [31:0] MASK_PLD = 32'h0000_FFFF;
   localparam logic [31:0] MASK_FVC = 32'h00FF_FFFF;
   localparam logic [63:0] RST_QUAL = 64'h0;
   // ****************************************
   // Field positions (low bit)
   // ****************************************
   localparam int P_DSP_RDQ_FULL = 7;
   localparam int P_DSP_LAT_EN   = 6;
   localparam int P_DSP_FVID     = 0;
   localparam int P_ISS_PLD_MODE = 7;
   localparam int P_ISS_MODE     = 4;
   localparam int P_ISS_FRAME    = 0;
   localparam int P_MAP_PATROL   = 10;
   localparam int P_MAP_EV3      = 9;
   localparam int P_MAP_ANYCMD   = 8;
   localparam int P_MAP_CMD      = 5;
   localparam int P_THR_DN       = 9;
   localparam int P_THR_UP       = 7;
   localparam int P_THR_MOD      = 4;
   localparam int P_THR_ALL      = 3;
   localparam int P_THR_TTSEL    = 0;
   localparam int P_PGT_EMPTY    = 11;
   localparam int P_PGT_TRIG     = 9;
   localparam int P_PGT_TRANS    = 7;
   localparam int P_PGT_OPEN     = 6;
   localparam int P_PGT_RANK     = 2;
   localparam int P_PGT_RANK_EN  = 1;
   localparam int P_PGT_DIR      = 0;
   localparam int P_PLD_TRIG     = 14;
   localparam int P_PLD_ADDRQ    = 13;
   localparam int P_PLD_DRAM     = 8;
   localparam int P_PLD_SNGL     = 7;
   localparam int P_PLD_FVID     = 1;
   localparam int P_PLD_MODEQ    = 0;
   localparam int P_FVC_INITERR  = 23;
   localparam int P_FVC_SUB0     = 11;
   localparam int P_FVC_RESP     = 8;
   localparam int P_FVC_BCMD     = 5;
   localparam int P_FVC_FVID     = 0;
   // ****************************************
   // Encodings and primary event codes
   // ****************************************
   localparam logic [2:0] SUB_NB_DEBUG = 3'h7;
   localparam logic [2:0] SUB_RESP     = 3'h6;
   localparam logic [2:0] SUB_BCMD     = 3'h5;
   localparam logic [2:0] SUB_FASTRST  = 3'h4;
   localparam logic [2:0] SUB_ALERT    = 3'h3;
   localparam logic [2:0] SUB_POISON   = 3'h2;
   localparam logic [2:0] SUB_ECC      = 3'h1;
   localparam logic [2:0] SUB_CRC      = 3'h0;
   localparam logic [2:0] MODE_MAX     = 3'h3;
   localparam logic [4:0] EV_DSP_FILL  = 5'h00;
   localparam logic [4:0] EV_TRIP_UP   = 5'h04;
   localparam logic [4:0] EV_TRIP_DN   = 5'h05;
   localparam logic [4:0] EV_ISS       = 5'h09;
   localparam logic [4:0] EV_DRAM      = 5'h0A;
   localparam logic [4:0] EV_RETRY     = 5'h0B;
   localparam logic [4:0] EV_PAR       = 5'h0C;
   localparam logic [4:0] EV_FVC0      = 5'h0D;
   localparam logic [4:0] EV_PATROL    = 5'h11;
   localparam logic [4:0] EV_TRANS     = 5'h12;
   localparam logic [4:0] EV_AUTOCLOSE = 5'h15;
   localparam logic [4:0] EV_PGT       = 5'h16;
   localparam logic [4:0] EV_TT        = 5'h19;
   localparam logic [4:0] EV_HOSTCMD   = 5'h1A;
   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic       wrq_empty, rdq_empty, wrq_full, rdq_full;
      logic       lat_valid, lat_complete;
      logic [5:0] lat_fvid;
      logic [2:0] cur_mode;
      logic       frame_valid;
      logic [3:0] frame_type;
      logic       patrol_rd, patrol_wr, patrol_accept;
      logic       map_trig, resp_valid;
      logic       host_cmd_valid;
      logic [2:0] host_cmd;
      logic       trip_up, trip_dn;
      logic [2:0] trip_module;
      logic [1:0] trip_cond;
      logic [7:0] throttle_active;
      logic       auto_close, empty_hit, page_open, policy_change;
      logic       pgt_trig1, pgt_trig2;
      logic       trans_valid, trans_wr;
      logic       tt_event;
      logic [3:0] tt_rank;
      logic       parity_err, pld_trig1, pld_trig2, addr_match;
      logic       dram_valid;
      logic [4:0] dram_cmd;
      logic       retry_valid;
      logic [5:0] retry_fvid;
      logic       nb_debug, init_err, fast_rst, alert, poison, ecc_err, crc_err;
      logic       fvc_resp_valid;
      logic [2:0] fvc_resp;
      logic       fvc_cmd_valid;
      logic [2:0] fvc_cmd;
      logic [4:0] fvc_fvid;
   } raw_ev_t;

   typedef struct packed {
      logic       dsp_fill, dsp_latency, iss_frame, sched_time;
      logic       dram_cmd, pld_retry, pld_trig;
      logic [3:0] fvc;
      logic       patrol, map_ev3, host_cmd;
      logic       trip_up, trip_dn, throttle_time;
      logic       auto_or_empty, pgt_page, pgt_transition, trans_cmd, pgt_state, tt_event;
   } qual_ev_t;
endpackage

// >>> verilog/mc_event_qualifier.sv
// Qualifier register bank and subevent filtering for the memory controller monitor.
// Assumes raw subunit events and counter selectors arrive on sys_clk, and the
// privileged register port is a one-cycle strobe interface on the same clock.
`timescale 1ns/1ns
module mc_event_qualifier
   import mc_qual_pkg::*;
#(
   parameter int NUM_CTRS = 6
) (
   // Clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 rstn,
   // Privileged register port
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   input  wire logic [2:0]           reg_idx,
   input  wire logic [63:0]          reg_wdata,
   output      logic [63:0]          reg_rdata_ff,
   output      logic                 reg_ack_ff,
   output      logic                 reg_err_ff,
   // Subunit events and counter selectors
   input  wire raw_ev_t              raw,
   input  wire logic [NUM_CTRS*5-1:0] inc_sel,
   // Qualified events
   output      qual_ev_t             qual_ff,
   output      logic [NUM_CTRS-1:0]  ctr_inc_ff
);
   if (NUM_CTRS < 1 || NUM_CTRS > 16) begin : g_bad_ctrs
      $error("NUM_CTRS out of range");
   end

   // ****************************************
   // Register bank
   // ****************************************
   logic [63:0] dsp_ff;
   logic [31:0] iss_ff, map_ff, thr_ff, pgt_ff, pld_ff, fvc_ff;

   wire hit_dsp = reg_wr && reg_idx == IDX_DSP;
   wire hit_iss = reg_wr && reg_idx == IDX_ISS;
   wire hit_map = reg_wr && reg_idx == IDX_MAP;
   wire hit_thr = reg_wr && reg_idx == IDX_THR;
   wire hit_pgt = reg_wr && reg_idx == IDX_PGT;
   wire hit_pld = reg_wr && reg_idx == IDX_PLD;
   wire hit_fvc = reg_wr && reg_idx == IDX_FVC;
   wire idx_ok  = reg_idx <= IDX_FVC;
   wire [31:0] wlo = reg_wdata[31:0];

   // Settings land at the write edge, so events use them from the next cycle on
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         dsp_ff <= RST_QUAL;
         iss_ff <= RST_QUAL[31:0];
         map_ff <= RST_QUAL[31:0];
         thr_ff <= RST_QUAL[31:0];
         pgt_ff <= RST_QUAL[31:0];
         pld_ff <= RST_QUAL[31:0];
         fvc_ff <= RST_QUAL[31:0];
      end else begin
         if (hit_dsp) dsp_ff <= reg_wdata & MASK_DSP;
         if (hit_iss) iss_ff <= wlo & MASK_ISS;
         if (hit_map) map_ff <= wlo & MASK_MAP;
         if (hit_thr) thr_ff <= wlo & MASK_THR;
         if (hit_pgt) pgt_ff <= wlo & MASK_PGT;
         if (hit_pld) pld_ff <= wlo & MASK_PLD;
         if (hit_fvc) fvc_ff <= wlo & MASK_FVC;
      end
   end

   logic [63:0] rd_mux;
   always_comb begin
      rd_mux = 64'h0;
      unique case (reg_idx)
         IDX_DSP: rd_mux = dsp_ff;
         IDX_ISS: rd_mux = {32'h0, iss_ff};
         IDX_MAP: rd_mux = {32'h0, map_ff};
         IDX_THR: rd_mux = {32'h0, thr_ff};
         IDX_PGT: rd_mux = {32'h0, pgt_ff};
         IDX_PLD: rd_mux = {32'h0, pld_ff};
         IDX_FVC: rd_mux = {32'h0, fvc_ff};
         default: rd_mux = 64'h0;
      endcase
   end

   // Unmapped index acks with error and reads zero
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         reg_rdata_ff <= 64'h0;
         reg_ack_ff   <= 1'b0;
         reg_err_ff   <= 1'b0;
      end else begin
         reg_rdata_ff <= reg_rd ? rd_mux : 64'h0;
         reg_ack_ff   <= reg_rd || reg_wr;
         reg_err_ff   <= (reg_rd || reg_wr) && !idx_ok;
      end
   end

   // ****************************************
   // Field decode
   // ****************************************
   wire [3:0] dsp_en     = dsp_ff[P_DSP_RDQ_FULL +: 4];
   wire       lat_en     = dsp_ff[P_DSP_LAT_EN];
   wire [5:0] lat_fvid   = dsp_ff[P_DSP_FVID +: 6];
   wire [2:0] mode_sel   = iss_ff[P_ISS_MODE +: 3];
   wire [3:0] frame_sel  = iss_ff[P_ISS_FRAME +: 4];
   wire [1:0] patrol_sel = map_ff[P_MAP_PATROL +: 2];
   wire       mapper_event_three_choice = map_ff[P_MAP_EV3];
   wire       any_cmd    = map_ff[P_MAP_ANYCMD];
   wire [2:0] cmd_sel    = map_ff[P_MAP_CMD +: 3];
   wire [1:0] falling_crossing_condition = thr_ff[P_THR_DN +: 2];
   wire [1:0] rising_crossing_condition  = thr_ff[P_THR_UP +: 2];
   wire [2:0] crossing_module_select     = thr_ff[P_THR_MOD +: 3];
   wire       every_module_crossing      = thr_ff[P_THR_ALL];
   wire [2:0] throttle_time_module       = thr_ff[P_THR_TTSEL +: 3];
   wire       empty_sel  = pgt_ff[P_PGT_EMPTY];
   wire [1:0] pgt_trig   = pgt_ff[P_PGT_TRIG +: 2];
   wire [1:0] trans_sel  = pgt_ff[P_PGT_TRANS +: 2];
   wire       open_sel   = pgt_ff[P_PGT_OPEN];
   wire [3:0] throttle_rank_select = pgt_ff[P_PGT_RANK +: 4];
   wire       rank_single          = pgt_ff[P_PGT_RANK_EN];
   wire       policy_transition_direction = pgt_ff[P_PGT_DIR];
   wire [1:0] pld_trig   = pld_ff[P_PLD_TRIG +: 2];
   wire       payload_address_qualify = pld_ff[P_PLD_ADDRQ];
   wire [4:0] dram_sel   = pld_ff[P_PLD_DRAM +: 5];
   wire       retry_sngl = pld_ff[P_PLD_SNGL];
   wire [5:0] retry_fvid = pld_ff[P_PLD_FVID +: 6];
   wire       mode_qual  = pld_ff[P_PLD_MODEQ];
   wire       init_sel   = fvc_ff[P_FVC_INITERR];
   wire [2:0] resp_sel   = fvc_ff[P_FVC_RESP +: 3];
   wire [2:0] bcmd_sel   = fvc_ff[P_FVC_BCMD +: 3];
   wire [4:0] fvid_sel   = fvc_ff[P_FVC_FVID +: 5];

   // ****************************************
   // Subunit qualification
   // ****************************************
   wire q_dsp_fill = |(dsp_en & {raw.wrq_empty, raw.rdq_empty, raw.wrq_full, raw.rdq_full});
   wire q_latency  = lat_en && raw.lat_valid && raw.lat_complete && raw.lat_fvid == lat_fvid;
   wire mode_legal = mode_sel <= MODE_MAX;
   wire q_sched    = mode_legal && raw.cur_mode == mode_sel;
   wire frame_legal = frame_sel <= 4'h3 || frame_sel == 4'h8 || frame_sel == 4'hC;
   wire q_frame    = raw.frame_valid && frame_legal && raw.frame_type == frame_sel;
   wire patrol_acc = raw.patrol_accept && (raw.patrol_rd || raw.patrol_wr);
   wire q_patrol   = patrol_sel == 2'h2 ? raw.patrol_wr :
                     patrol_sel == 2'h1 ? raw.patrol_rd : patrol_acc;
   wire q_map_ev3  = mapper_event_three_choice ? raw.map_trig : raw.resp_valid;
   wire q_host     = raw.host_cmd_valid && (any_cmd || raw.host_cmd == cmd_sel);
   wire mod_hit    = every_module_crossing || raw.trip_module == crossing_module_select;
   wire q_trip_up  = raw.trip_up && mod_hit && raw.trip_cond == rising_crossing_condition;
   wire q_trip_dn  = raw.trip_dn && mod_hit && raw.trip_cond == falling_crossing_condition;
   wire q_thr_time = raw.throttle_active[throttle_time_module];
   wire q_auto     = empty_sel ? raw.empty_hit : raw.auto_close;
   wire q_pstate   = open_sel ? raw.page_open : !raw.page_open;
   wire q_ptrans   = raw.policy_change && (raw.page_open == policy_transition_direction);
   wire q_pgt_page = pgt_trig == 2'h0 ? q_pstate :
                     pgt_trig == 2'h1 ? raw.pgt_trig1 :
                     pgt_trig == 2'h2 ? raw.pgt_trig2 : 1'b0;
   wire q_trans    = raw.trans_valid && (trans_sel == 2'h0 ||
                     (trans_sel == 2'h1 && raw.trans_wr) ||
                     (trans_sel == 2'h2 && !raw.trans_wr));
   wire q_tt       = raw.tt_event && (!rank_single || raw.tt_rank == throttle_rank_select);
   wire trig_raw   = pld_trig == 2'h0 ? raw.parity_err :
                     pld_trig == 2'h1 ? raw.pld_trig1 :
                     pld_trig == 2'h2 ? raw.pld_trig2 : 1'b0;
   // Address qualification only gates trigger matches, never parity errors
   wire q_pld_trig = trig_raw && (!payload_address_qualify || pld_trig == 2'h0 || raw.addr_match);
   wire mode_ok    = !mode_qual || (mode_legal && raw.cur_mode == mode_sel);
   wire q_dram     = raw.dram_valid && raw.dram_cmd == dram_sel && mode_ok;
   wire q_retry    = raw.retry_valid && (!retry_sngl || raw.retry_fvid == retry_fvid);
   wire resp_hit   = raw.fvc_resp_valid && raw.fvc_resp == resp_sel && raw.fvc_fvid == fvid_sel;
   wire cmd_hit    = raw.fvc_cmd_valid && raw.fvc_cmd == bcmd_sel && raw.fvc_fvid == fvid_sel;
   wire nb_sel     = init_sel ? raw.init_err : raw.nb_debug;
   wire [7:0] sub_src = {nb_sel, resp_hit, cmd_hit, raw.fast_rst, raw.alert,
                         raw.poison, raw.ecc_err, raw.crc_err};

   // Each selector indexes the same source vector independently
   wire [3:0] q_fvc;
   for (genvar g = 0; g < 4; g++) begin : g_sub
      assign q_fvc[g] = sub_src[fvc_ff[P_FVC_SUB0 + 3*g +: 3]];
   end

   qual_ev_t nxt_qual;
   always_comb begin
      nxt_qual = '0;
      nxt_qual.dsp_fill       = q_dsp_fill;
      nxt_qual.dsp_latency    = q_latency;
      nxt_qual.iss_frame      = q_frame;
      nxt_qual.sched_time     = q_sched;
      nxt_qual.dram_cmd       = q_dram;
      nxt_qual.pld_retry      = q_retry;
      nxt_qual.pld_trig       = q_pld_trig;
      nxt_qual.fvc            = q_fvc;
      nxt_qual.patrol         = q_patrol;
      nxt_qual.map_ev3        = q_map_ev3;
      nxt_qual.host_cmd       = q_host;
      nxt_qual.trip_up        = q_trip_up;
      nxt_qual.trip_dn        = q_trip_dn;
      nxt_qual.throttle_time  = q_thr_time;
      nxt_qual.auto_or_empty  = q_auto;
      nxt_qual.pgt_page       = q_pgt_page;
      nxt_qual.pgt_transition = q_ptrans;
      nxt_qual.trans_cmd      = q_trans;
      nxt_qual.pgt_state      = q_pstate;
      nxt_qual.tt_event       = q_tt;
   end

   // ****************************************
   // Counter steering
   // ****************************************
   logic [31:0] ev_vec;
   always_comb begin
      ev_vec               = 32'h0;
      ev_vec[EV_DSP_FILL]  = q_dsp_fill;
      ev_vec[EV_TRIP_UP]   = q_trip_up;
      ev_vec[EV_TRIP_DN]   = q_trip_dn;
      ev_vec[EV_ISS]       = q_frame;
      ev_vec[EV_DRAM]      = q_dram;
      ev_vec[EV_RETRY]     = q_retry;
      ev_vec[EV_PAR]       = q_pld_trig;
      ev_vec[EV_FVC0 +: 4] = q_fvc;
      ev_vec[EV_PATROL]    = q_patrol;
      ev_vec[EV_TRANS]     = q_trans;
      ev_vec[EV_AUTOCLOSE] = q_auto;
      ev_vec[EV_PGT]       = q_pgt_page;
      ev_vec[EV_TT]        = q_tt;
      ev_vec[EV_HOSTCMD]   = q_host;
   end

   wire [NUM_CTRS-1:0] nxt_ctr_inc;
   for (genvar c = 0; c < NUM_CTRS; c++) begin : g_ctr
      assign nxt_ctr_inc[c] = ev_vec[inc_sel[c*5 +: 5]];
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         qual_ff    <= '0;
         ctr_inc_ff <= '0;
      end else begin
         qual_ff    <= nxt_qual;
         ctr_inc_ff <= nxt_ctr_inc;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   a_dsp_fill_gate: assert property ($past(dsp_en) == 4'h0 |-> !qual_ff.dsp_fill)
      else $error("fill trigger without any enable");
   a_latency_match: assert property (qual_ff.dsp_latency |->
      $past(raw.lat_complete) && $past(raw.lat_fvid) == $past(lat_fvid))
      else $error("latency counted for wrong index");
   a_frame_reserved: assert property (!$past(frame_legal) |-> !qual_ff.iss_frame)
      else $error("reserved frame code counted");
   a_patrol_write: assert property ($past(patrol_sel) == 2'h2 |-> qual_ff.patrol == $past(raw.patrol_wr))
      else $error("patrol write selection wrong");
   a_host_cmd_any: assert property ($past(any_cmd) && $past(raw.host_cmd_valid) |-> qual_ff.host_cmd)
      else $error("host command lost with any-command set");
   a_trip_module: assert property (qual_ff.trip_up |->
      $past(every_module_crossing) || $past(raw.trip_module) == $past(crossing_module_select))
      else $error("crossing from unselected module");
   a_tt_rank: assert property ($past(rank_single) && qual_ff.tt_event |->
      $past(raw.tt_rank) == $past(throttle_rank_select))
      else $error("throttle event for other rank");
   a_pgt_reserved: assert property ($past(pgt_trig) == 2'h3 |-> !qual_ff.pgt_page)
      else $error("reserved page event counted");
   a_retry_index: assert property ($past(retry_sngl) && qual_ff.pld_retry |->
      $past(raw.retry_fvid) == $past(retry_fvid))
      else $error("retry counted for other index");
   a_dram_mode: assert property ($past(mode_qual) && qual_ff.dram_cmd |->
      $past(raw.cur_mode) == $past(mode_sel))
      else $error("dram command outside selected mode");
   a_write_effect: assert property (hit_pgt && wlo[P_PGT_OPEN] && raw.page_open ##1 $stable(raw.page_open)
      |-> ##1 qual_ff.pgt_state)
      else $error("new policy setting not applied next cycle");
   a_ctr_steer: assert property (ctr_inc_ff[0] |-> $past(ev_vec[inc_sel[4:0]]))
      else $error("counter stepped on unselected event");
   a_trans_reserved: assert property ($past(trans_sel) == 2'h3 |-> !qual_ff.trans_cmd)
      else $error("reserved translated selection counted");
   a_pld_reserved: assert property ($past(pld_trig) == 2'h3 |-> !qual_ff.pld_trig)
      else $error("reserved payload trigger counted");
   a_reg_ack: assert property (reg_wr || reg_rd |=> reg_ack_ff)
      else $error("register access not acknowledged");

   c_dram_mode: cover property (qual_ff.dram_cmd && $past(mode_qual));
   c_fvc_four: cover property (qual_ff.fvc == 4'hF);
   c_ctr_step: cover property (reg_wr ##1 ctr_inc_ff[0]);
   c_trip_all: cover property (qual_ff.trip_up && $past(every_module_crossing));
endmodule

// >>> dv/test_mc_event_qualifier.sv
// Self-checking bench for the event qualifier bank.
// Assumes the bank acks every strobe one cycle later, events one cycle late.
`timescale 1ns/1ns
module test_mc_event_qualifier;
   import mc_qual_pkg::*;
   // ********
   // Signals
   // ********
   logic        sys_clk   = 1'b0;
   logic        rstn      = 1'b0;
   logic        reg_wr    = 1'b0;
   logic        reg_rd    = 1'b0;
   logic [2:0]  reg_idx   = 3'h0;
   logic [63:0] reg_wdata = 64'h0;
   raw_ev_t     raw       = '0;
   logic [29:0] inc_sel   = 30'h0;
   logic [15:0] lfsr_ff   = 16'h6956;
   logic [63:0] reg_rdata_ff;
   logic        reg_ack_ff;
   logic        reg_err_ff;
   qual_ev_t    qual_ff;
   logic [5:0]  ctr_inc_ff;
   logic [63:0] rd_data;
   logic [15:0] a;
   logic [15:0] b;
   logic        hit;
   logic [63:0] r;
   logic [31:0] thr;
   logic [31:0] pgt;
   logic [31:0] fvc;
   logic [31:0] mp;
   logic [7:0]  e;
   int          error_cnt = 0;
   int          n_checks  = 0;
   always #10 sys_clk = ~sys_clk;
   mc_event_qualifier #(.NUM_CTRS(6)) DUT (.sys_clk(sys_clk), .rstn(rstn), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
      .reg_ack_ff(reg_ack_ff), .reg_err_ff(reg_err_ff), .raw(raw), .inc_sel(inc_sel),
      .qual_ff(qual_ff), .ctr_inc_ff(ctr_inc_ff));
   // ********
   // Helpers
   // ********
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [63:0] reg_mask(input logic [2:0] i);
      case (i)
         IDX_DSP: return MASK_DSP;
         IDX_ISS: return {32'h0, MASK_ISS};
         IDX_MAP: return {32'h0, MASK_MAP};
         IDX_THR: return {32'h0, MASK_THR};
         IDX_PGT: return {32'h0, MASK_PGT};
         IDX_PLD: return {32'h0, MASK_PLD};
         IDX_FVC: return {32'h0, MASK_FVC};
         default: return 64'h0;
      endcase
   endfunction
   // Only six frame codes are defined; the rest must stay silent
   function automatic logic frame_hit(input logic [3:0] sel, input logic [3:0] typ);
      return (sel == typ) && (sel < 4'h4 || sel == 4'h8 || sel == 4'hC);
   endfunction
   function automatic logic sub_exp(input logic [2:0] code);
      case (code)
         3'h7: return fvc[23] ? raw.init_err : raw.nb_debug;
         3'h6: return raw.fvc_resp_valid && raw.fvc_resp == fvc[10:8] && raw.fvc_fvid == fvc[4:0];
         3'h5: return raw.fvc_cmd_valid && raw.fvc_cmd == fvc[7:5] && raw.fvc_fvid == fvc[4:0];
         3'h4: return raw.fast_rst;
         3'h3: return raw.alert;
         3'h2: return raw.poison;
         3'h1: return raw.ecc_err;
         default: return raw.crc_err;
      endcase
   endfunction
   task automatic draw();
      for (int j = 0; j < 4; j++) begin
         lfsr_ff = lfsr_next(lfsr_ff);
         r = {r[47:0], lfsr_ff};
      end
   endtask
   task automatic step();
      @(posedge sys_clk);
      #1;
   endtask
   task automatic cmp_reg(input logic [63:0] got, input logic [63:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp, input string what);
      cmp_reg({63'h0, got}, {63'h0, exp}, what);
   endtask
   // Strobe stays up between back-to-back calls, so no signal toggles twice
   task automatic access(input logic wr, input logic [2:0] idx, input logic [63:0] data, input logic err);
      reg_wr = wr;
      reg_rd = ~wr;
      reg_idx = idx;
      reg_wdata = data;
      step();
      cmp_bit(reg_ack_ff, 1'b1, "ack");
      cmp_bit(reg_err_ff, err, "err");
      rd_data = reg_rdata_ff;
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #20000;
      error_cnt++;
      print_verdict();
   end
   // ********
   // Sequence
   // ********
   initial begin
      repeat (6) @(posedge sys_clk);
      #1;
      rstn = 1'b1;
      for (int i = 0; i < 8; i++) begin
         access(1'b0, i[2:0], 64'h0, i == 7);
         cmp_reg(rd_data, RST_QUAL, "reset value");
         lfsr_ff = lfsr_next(lfsr_ff);
         access(1'b1, i[2:0], i[0] ? ~64'h0 : {4{lfsr_ff}}, i == 7);
         access(1'b0, i[2:0], 64'h0, i == 7);
         cmp_reg(rd_data, (i[0] ? ~64'h0 : {4{lfsr_ff}}) & reg_mask(i[2:0]), "read back");
      end
      inc_sel = {20'h0, 5'h1B, EV_ISS};
      for (int s = 0; s < 16; s++) begin
         access(1'b1, IDX_ISS, 64'(s), 1'b0);
         reg_wr = 1'b0;
         raw.frame_valid = 1'b1;
         raw.frame_type = s[3:0];
         step();
         cmp_bit(qual_ff.iss_frame, frame_hit(s[3:0], s[3:0]), "frame");
         cmp_bit(ctr_inc_ff[0], frame_hit(s[3:0], s[3:0]), "frame counter");
         raw.frame_type = ~s[3:0];
         step();
         cmp_bit(qual_ff.iss_frame, 1'b0, "other frame");
      end
      inc_sel[4:0] = EV_HOSTCMD;
      for (int k = 0; k < 32; k++) begin
         lfsr_ff = lfsr_next(lfsr_ff);
         a = lfsr_ff;
         lfsr_ff = lfsr_next(lfsr_ff);
         b = lfsr_ff;
         draw();
         access(1'b1, IDX_DSP, {53'h0, a[3:0], a[15], a[10:5]}, 1'b0);
         access(1'b1, IDX_MAP, {55'h0, a[11], a[14:12], 5'h0}, 1'b0);
         access(1'b1, IDX_PLD, {48'h0, r[15:8], a[4], a[10:5], r[0]}, 1'b0);
         access(1'b1, IDX_ISS, {57'h0, r[18:16], 4'h0}, 1'b0);
         reg_wr = 1'b0;
         {raw.wrq_empty, raw.rdq_empty, raw.wrq_full, raw.rdq_full} = b[3:0];
         raw.host_cmd_valid = 1'b1;
         raw.host_cmd = k[3] ? a[14:12] : b[6:4];
         raw.retry_valid = 1'b1;
         raw.retry_fvid = k[2] ? a[10:5] : b[15:10];
         raw.lat_valid = 1'b1;
         raw.lat_complete = b[7];
         raw.lat_fvid = raw.retry_fvid;
         raw.cur_mode = k[1] ? r[18:16] : r[21:19];
         raw.dram_valid = 1'b1;
         raw.dram_cmd = k[0] ? r[12:8] : r[26:22];
         {raw.parity_err, raw.pld_trig1, raw.pld_trig2, raw.addr_match} = r[30:27];
         hit = a[11] || raw.host_cmd == a[14:12];
         e[0] = r[18:16] < 3'h4 && raw.cur_mode == r[18:16];
         e[1] = (r[15:14] == 2'h0 && raw.parity_err) || ((!r[13] || raw.addr_match) &&
                ((r[15:14] == 2'h1 && raw.pld_trig1) || (r[15:14] == 2'h2 && raw.pld_trig2)));
         step();
         cmp_bit(qual_ff.dsp_fill, |(a[3:0] & b[3:0]), "fill");
         cmp_bit(qual_ff.host_cmd, hit, "host command");
         cmp_bit(ctr_inc_ff[0], hit, "host counter");
         cmp_bit(ctr_inc_ff[1], 1'b0, "unused code");
         cmp_bit(qual_ff.pld_retry, !a[4] || raw.retry_fvid == a[10:5], "retry");
         cmp_bit(qual_ff.dsp_latency, a[15] && b[7] && raw.retry_fvid == a[10:5], "latency");
         cmp_bit(qual_ff.sched_time, e[0], "mode time");
         cmp_bit(qual_ff.dram_cmd, raw.dram_cmd == r[12:8] && (!r[0] || e[0]), "dram command");
         cmp_bit(qual_ff.pld_trig, e[1], "payload trigger");
      end
      inc_sel = {EV_FVC0 + 5'h3, EV_FVC0 + 5'h2, EV_FVC0 + 5'h1, EV_FVC0, EV_TT, EV_PGT};
      for (int k = 0; k < 24; k++) begin
         draw();
         thr = r[31:0];
         pgt = r[63:32];
         draw();
         fvc = r[31:0];
         mp = r[63:32];
         access(1'b1, IDX_THR, {32'h0, thr}, 1'b0);
         access(1'b1, IDX_PGT, {32'h0, pgt}, 1'b0);
         access(1'b1, IDX_FVC, {32'h0, fvc}, 1'b0);
         access(1'b1, IDX_MAP, {32'h0, mp}, 1'b0);
         reg_wr = 1'b0;
         draw();
         raw = {r[29:0], r};
         // Odd passes force the match fields so the narrow selectors really hit
         if (k[0]) begin
            raw.trip_module = thr[6:4];
            raw.trip_cond = k[1] ? thr[8:7] : thr[10:9];
            raw.tt_rank = pgt[5:2];
            {raw.fvc_resp, raw.fvc_cmd, raw.fvc_fvid} = fvc[10:0];
         end
         hit = thr[3] || raw.trip_module == thr[6:4];
         e[5:2] = {sub_exp(fvc[22:20]), sub_exp(fvc[19:17]), sub_exp(fvc[16:14]), sub_exp(fvc[13:11])};
         e[1] = raw.tt_event && (!pgt[1] || raw.tt_rank == pgt[5:2]);
         e[0] = pgt[10:9] == 2'h0 ? raw.page_open == pgt[6] :
                pgt[10:9] == 2'h1 ? raw.pgt_trig1 : pgt[10:9] == 2'h2 && raw.pgt_trig2;
         e[6] = raw.trans_valid && (pgt[8:7] == 2'h0 || pgt[8:7] == {!raw.trans_wr, raw.trans_wr});
         e[7] = mp[11:10] == 2'h2 ? raw.patrol_wr : mp[11:10] == 2'h1 ? raw.patrol_rd :
                raw.patrol_accept && (raw.patrol_rd || raw.patrol_wr);
         step();
         cmp_bit(qual_ff.trip_up, raw.trip_up && hit && raw.trip_cond == thr[8:7], "trip up");
         cmp_bit(qual_ff.trip_dn, raw.trip_dn && hit && raw.trip_cond == thr[10:9], "trip down");
         cmp_bit(qual_ff.throttle_time, raw.throttle_active[thr[2:0]], "throttle time");
         cmp_bit(qual_ff.auto_or_empty, pgt[11] ? raw.empty_hit : raw.auto_close, "auto close");
         cmp_bit(qual_ff.pgt_page, e[0], "page event");
         cmp_bit(qual_ff.trans_cmd, e[6], "translated");
         cmp_bit(qual_ff.pgt_state, raw.page_open == pgt[6], "policy time");
         cmp_bit(qual_ff.tt_event, e[1], "rank");
         cmp_bit(qual_ff.pgt_transition, raw.policy_change && raw.page_open == pgt[0], "transition");
         cmp_bit(qual_ff.patrol, e[7], "patrol");
         cmp_bit(qual_ff.map_ev3, mp[9] ? raw.map_trig : raw.resp_valid, "mapper event");
         cmp_reg({60'h0, qual_ff.fvc}, {60'h0, e[5:2]}, "subevents");
         cmp_reg({58'h0, ctr_inc_ff}, {58'h0, e[5:0]}, "steering");
      end
      print_verdict();
   end
endmodule
